// file: shared/sdcd_pkg.sv
// constants and types for the sdram command decoder
package sdcd_pkg;
   typedef enum logic [4:0] {
      SDCD_DES  = 5'h00,
      SDCD_NOP  = 5'h01,
      SDCD_MRS  = 5'h02,
      SDCD_REF  = 5'h03,
      SDCD_SRE  = 5'h04,
      SDCD_SRX  = 5'h05,
      SDCD_PRE  = 5'h06,
      SDCD_PREA = 5'h07,
      SDCD_RFU  = 5'h08,
      SDCD_ACT  = 5'h09,
      SDCD_WR   = 5'h0a,
      SDCD_RD   = 5'h0b,
      SDCD_PDE  = 5'h0c,
      SDCD_PDX  = 5'h0d,
      SDCD_ZQCL = 5'h0e,
      SDCD_ZQCS = 5'h0f,
      SDCD_ILL  = 5'h10
   } sdcd_cmd_t;

   typedef enum logic [1:0] {
      SDCD_ST_IDLE = 2'h0,
      SDCD_ST_PD   = 2'h1,
      SDCD_ST_SR   = 2'h2
   } sdcd_state_t;

   localparam logic [2:0] SDCD_MR6_SEL     = 3'h6;
   localparam int         SDCD_MR6_EN_BIT  = 7;
   localparam int         SDCD_MR6_RNG_BIT = 6;
   localparam int         SDCD_VAL_W       = 6;
   localparam int         SDCD_AP_BIT      = 10;
   localparam int         SDCD_BC_BIT      = 12;
   localparam int         SDCD_RATE_LSB    = 10;
   localparam logic [2:0] SDCD_RATE_RST    = 3'h0;
   localparam logic [7:0] SDCD_MR6_RST     = 8'h00;
   localparam logic [5:0] SDCD_VAL_MAX     = 6'h31; // fifty settings
   localparam logic [3:0] SDCD_BURST_BL8   = 4'h4;  // clocks of bl8
   localparam logic [3:0] SDCD_BURST_BC4   = 4'h2;  // clocks of bc4
   // range bases and step in hundredths of a percent of supply
   localparam int         SDCD_RANGE1_BASE = 6000;
   localparam int         SDCD_RANGE2_BASE = 4500;
   localparam int         SDCD_STEP        = 65;
endpackage

// file: verif/sdcd_ctrl_model.sv
// controller-side model that drives the sdram command pins
`timescale 1ns/10ps
module sdcd_ctrl_model
(
   // clock
   input  wire logic   clk,
   // pins toward the device
   output logic        reset_n,
   output logic        cke,
   output logic        cs_n,
   output logic        act_n,
   output logic        ras_n,
   output logic        cas_n,
   output logic        we_n,
   output logic [1:0]  bg,
   output logic [1:0]  ba,
   output logic [17:0] addr,
   output logic        odt
);
   // quiet pins at time zero, pin reset held high
   initial
   begin
      reset_n = 1'b1;
      {cke, cs_n, act_n, ras_n, cas_n, we_n, odt} = 7'h7e;
      {bg, ba, addr} = 22'h000000;
   end

   // one selected command, a17 kept low
   task automatic drive(input logic c, a, r, ca, w, input logic [1:0] g, b,
                        input logic [17:0] ad);
      @(posedge clk);
      {cke, cs_n, act_n, ras_n, cas_n, we_n} <= {c, 1'b0, a, r, ca, w};
      {bg, ba, addr} <= {g, b, 1'b0, ad[16:0]};
   endtask

   // deselect, cke moved on the edge, dont-care pins scrambled
   task automatic idle(input logic c);
      @(posedge clk);
      {cke, cs_n} <= {c, 1'b1};
      {act_n, ras_n, cas_n, we_n} <= ~{act_n, ras_n, cas_n, we_n};
      {bg, ba, addr} <= ~{bg, ba, addr};
   endtask

   // termination request level
   task automatic set_odt(input logic v);
      @(posedge clk);
      odt <= v;
   endtask

   // one-cycle pin reset pulse
   task automatic pin_reset();
      @(posedge clk);
      reset_n <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b1;
   endtask
endmodule

// file: verif/tb_sdram_command_decoder.sv
// testbench of the sdram command decoder
`timescale 1ns/10ps
module tb_sdram_command_decoder;
   import sdcd_pkg::*;
   logic        clk;
   logic        rst;
   logic        otf;
   logic        en, bc4;
   logic        rn, cke, cs, act, ras, cas, we, odt;
   logic [1:0]  bg, ba;
   logic [17:0] addr;
   logic [4:0]  cmd_o;
   logic        vld, ap, c4, busy, pd, sr, rq, odta, cen, crg;
   logic [1:0]  cbg, cba;
   logic [16:0] row;
   logic [2:0]  rate;
   logic [5:0]  cval;
   logic [13:0] lvl;
   logic [3:0]  dqo, dqe;
   int          n_mismatch = 0;
   int          check_count = 0;
   // pins act, ras, cas, we, a10 and the command they mean
   localparam logic [4:0] PINS [10] = '{5'h10, 5'h12, 5'h14, 5'h15, 5'h0e,
                                       5'h18, 5'h1a, 5'h1e, 5'h1d, 5'h1c};
   localparam sdcd_cmd_t EXP [10] = '{SDCD_MRS, SDCD_REF, SDCD_PRE, SDCD_PREA,
      SDCD_ACT, SDCD_WR, SDCD_RD, SDCD_NOP, SDCD_ZQCL, SDCD_ZQCS};

   sdcd_ctrl_model u_ctrl (.clk(clk), .reset_n(rn), .cke(cke), .cs_n(cs),
      .act_n(act), .ras_n(ras), .cas_n(cas), .we_n(we), .bg(bg), .ba(ba),
      .addr(addr), .odt(odt));

   sdcd_decoder dut (.SYS_CLK(clk), .CLK_EN(en), .RST(rst), .RESET_N(rn),
      .CKE(cke), .CS_N(cs), .ACT_N(act), .RAS_N_A16(ras), .CAS_N_A15(cas),
      .WE_N_A14(we), .BG(bg), .BA(ba), .ADDR(addr), .ODT(odt),
      .OTF_BURST_EN(otf), .BC4_FIXED(bc4), .CMD(cmd_o), .CMD_VALID(vld),
      .CMD_BG(cbg), .CMD_BA(cba), .ROW_ADDR(row), .AUTO_PRE(ap), .CHOP4(c4),
      .BURST_BUSY(busy), .POWER_DOWN(pd), .SELF_REFRESH(sr),
      .REFRESH_REQ(rq), .ODT_ACTIVE(odta), .DATA_RATE(rate),
      .CAL_ENABLE(cen), .CAL_RANGE(crg), .CAL_VALUE(cval),
      .REF_LEVEL_BP(lvl), .DQ_OUT(dqo), .DQ_OE(dqe));

   // 40 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // compare and count
   task automatic check(input string what, input logic [16:0] seen,
                        input logic [16:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // selected command, then a deselect edge, outputs settled
   task automatic cmd(input logic c, a, r, ca, w, input logic [1:0] g, b,
                      input logic [17:0] ad);
      u_ctrl.drive(c, a, r, ca, w, g, b, ad);
      u_ctrl.idle(c);
      #1;
   endtask

   // counts and verdict
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // watchdog
   initial
   begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      summarize();
   end

   // test sequence
   initial
   begin
      rst = 1'b1;
      otf = 1'b1;
      en = 1'b1;
      bc4 = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      u_ctrl.idle(1'b1);
      #1;
      check("cmd", cmd_o, SDCD_DES);
      check("vld", vld, 1'b0);
      check("oe", dqe, 4'h0);
      $display("test reset done");
      // every table code, odt toggling; reserved code never sent
      for (int i = 0; i < 10; i++)
      begin
         u_ctrl.set_odt(i[0]);
         cmd(1'b1, PINS[i][4], PINS[i][3], PINS[i][2], PINS[i][1], 2'h1,
             2'h2, {7'h02, PINS[i][0], 10'h000});
         check("cmd", cmd_o, EXP[i]);
         check("vld", vld, 1'b1);
         u_ctrl.idle(1'b1);
         #1;
         check("des", cmd_o, SDCD_DES);
      end
      $display("test table done");
      cmd(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'h3, 2'h1, 18'h02345);
      check("row", row, 17'h16345);
      check("bank", {cbg, cba}, 4'hd);
      repeat (6) u_ctrl.idle(1'b1);
      cmd(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2'h2, 2'h3, 18'h00400);
      check("rd", cmd_o, SDCD_RD);
      check("ap", ap, 1'b1);
      check("c4", c4, 1'b1);
      check("busy", busy, 1'b1);
      repeat (6) u_ctrl.idle(1'b1);
      #1;
      check("idle", busy, 1'b0);
      cmd(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 18'h01000);
      check("c8", c4, 1'b0);
      // fixed burst mode, a12 no longer picks the chop
      @(posedge clk) {otf, bc4} <= 2'b01;
      cmd(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 18'h01000);
      check("fix4", c4, 1'b1);
      @(posedge clk) {otf, bc4} <= 2'b10;
      $display("test burst done");
      // mode register six, enable set with every value write
      cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h3, 2'h0, 18'h00cc5);
      check("rate", rate, 3'h3);
      check("cal", {cen, crg, cval}, 8'hc5);
      check("oe", dqe, 4'h1);
      u_ctrl.idle(1'b1);
      #1;
      check("lvl", lvl, 17'(SDCD_RANGE2_BASE + 5 * SDCD_STEP));
      cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h3, 2'h0, 18'h000b1);
      u_ctrl.idle(1'b1);
      #1;
      check("lvl", lvl, 17'(SDCD_RANGE1_BASE + 49 * SDCD_STEP));
      cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h3, 2'h2, 18'h00000);
      check("keep", {cen, crg, cval}, 8'hb1);
      // enable low freezes the mode register write
      @(posedge clk) en <= 1'b0;
      cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h3, 2'h0, 18'h00080);
      check("frz", {cen, crg, cval}, 8'hb1);
      @(posedge clk) en <= 1'b1;
      $display("test mr6 done");
      repeat (2) u_ctrl.idle(1'b0);
      #1;
      check("pd", pd, 1'b1);
      check("rq", rq, 1'b0);
      repeat (2) u_ctrl.idle(1'b1);
      #1;
      check("pdx", pd, 1'b0);
      u_ctrl.set_odt(1'b1);
      cmd(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 2'h0, 18'h00000);
      u_ctrl.idle(1'b0);
      #1;
      check("sr", sr, 1'b1);
      check("odt", odta, 1'b0);
      repeat (3) u_ctrl.idle(1'b1);
      #1;
      check("srx", sr, 1'b0);
      check("odt", odta, 1'b1);
      $display("test power done");
      u_ctrl.pin_reset();
      u_ctrl.idle(1'b1);
      #1;
      check("rst", {cen, rate}, 4'h0);
      $display("test pin reset done");
      summarize();
   end
endmodule

// file: verilog/sdcd_decoder.sv
// command decoder of the sdram device
`timescale 1ns/10ps
module sdcd_decoder
   import sdcd_pkg::*;
(
   // clock, enable and reset
   input  wire logic        SYS_CLK,
   input  wire logic        CLK_EN,
   input  wire logic        RST,
   input  wire logic        RESET_N,
   // command pins
   input  wire logic        CKE,
   input  wire logic        CS_N,
   input  wire logic        ACT_N,
   input  wire logic        RAS_N_A16,
   input  wire logic        CAS_N_A15,
   input  wire logic        WE_N_A14,
   input  wire logic [1:0]  BG,
   input  wire logic [1:0]  BA,
   input  wire logic [17:0] ADDR,
   input  wire logic        ODT,
   // mode settings
   input  wire logic        OTF_BURST_EN,
   input  wire logic        BC4_FIXED,
   // decoded command
   output logic [4:0]       CMD,
   output logic             CMD_VALID,
   output logic [1:0]       CMD_BG,
   output logic [1:0]       CMD_BA,
   output logic [16:0]      ROW_ADDR,
   output logic             AUTO_PRE,
   output logic             CHOP4,
   output logic             BURST_BUSY,
   // power state
   output logic             POWER_DOWN,
   output logic             SELF_REFRESH,
   output logic             REFRESH_REQ,
   output logic             ODT_ACTIVE,
   // mode register six view
   output logic [2:0]       DATA_RATE,
   output logic             CAL_ENABLE,
   output logic             CAL_RANGE,
   output logic [5:0]       CAL_VALUE,
   output logic [13:0]      REF_LEVEL_BP,
   // reference level monitor on dq[3:0]
   output logic [3:0]       DQ_OUT,
   output logic [3:0]       DQ_OE
);

   logic             cke_q;
   logic             rst_any;
   sdcd_cmd_t        cmd_d;
   sdcd_cmd_t        cmd_q;
   sdcd_state_t      st_q;
   logic [7:0]       mr6_q;
   logic [2:0]       rate_q;
   logic [3:0]       burst_q;
   logic             chop_d;
   logic [1:0]       bg_q;
   logic [1:0]       ba_q;
   logic [16:0]      row_q;
   logic             ap_q;
   logic             chop_q;
   logic             valid_q;
   logic             ref_q;
   logic             odt_q;
   logic [13:0]      lvl_q;

   // active low pin reset joins the synchronous reset
   assign rst_any = RST | ~RESET_N;

   // previous cke level for entry and exit decode
   always_ff @(posedge SYS_CLK)
   begin
      if (rst_any)
         cke_q <= 1'b1;
      else if (CLK_EN)
         cke_q <= CKE;
   end

   // decode of the command pins at the rising edge
   always_comb
   begin
      cmd_d = SDCD_ILL;
      if (CS_N)
      begin
         if (cke_q && !CKE)
            cmd_d = SDCD_PDE;
         else if (!cke_q && CKE)
            cmd_d = (st_q == SDCD_ST_SR) ? SDCD_SRX : SDCD_PDX;
         else
            cmd_d = SDCD_DES;
      end
      else if (!ACT_N)
         cmd_d = (cke_q && CKE) ? SDCD_ACT : SDCD_ILL;
      else
      begin
         unique case ({RAS_N_A16, CAS_N_A15, WE_N_A14})
            3'h0: cmd_d = (cke_q && CKE) ? SDCD_MRS : SDCD_ILL;
            3'h1:
            begin
               if (cke_q && CKE)
                  cmd_d = SDCD_REF;
               else if (cke_q)
                  cmd_d = SDCD_SRE;
               else
                  cmd_d = SDCD_ILL;
            end
            3'h2: cmd_d = ADDR[SDCD_AP_BIT] ? SDCD_PREA : SDCD_PRE;
            3'h3: cmd_d = SDCD_RFU;
            3'h4: cmd_d = SDCD_WR;
            3'h5: cmd_d = SDCD_RD;
            3'h6: cmd_d = ADDR[SDCD_AP_BIT] ? SDCD_ZQCL : SDCD_ZQCS;
            3'h7: cmd_d = SDCD_NOP;
         endcase
         if (!(cke_q && CKE) && cmd_d != SDCD_SRE)
            cmd_d = SDCD_ILL;
      end
   end

   // chop selection, otf via a12 else the fixed mode
   assign chop_d = OTF_BURST_EN ? ~ADDR[SDCD_BC_BIT] : BC4_FIXED;

   // registered command and its address fields
   always_ff @(posedge SYS_CLK)
   begin
      if (rst_any)
      begin
         cmd_q   <= SDCD_DES;
         valid_q <= 1'b0;
         bg_q    <= 2'h0;
         ba_q    <= 2'h0;
         row_q   <= 17'h00000;
         ap_q    <= 1'b0;
         chop_q  <= 1'b0;
      end
      else if (CLK_EN)
      begin
         cmd_q   <= cmd_d;
         valid_q <= !CS_N;
         if (!CS_N)
         begin
            bg_q   <= BG;
            ba_q   <= BA;
            row_q  <= {RAS_N_A16, CAS_N_A15, WE_N_A14, ADDR[13:0]};
            ap_q   <= ADDR[SDCD_AP_BIT];
            chop_q <= chop_d;
         end
      end
   end

   // burst counter, never cut short by later commands
   always_ff @(posedge SYS_CLK)
   begin
      if (rst_any)
         burst_q <= 4'h0;
      else if (CLK_EN)
      begin
         if (burst_q != 4'h0)
            burst_q <= burst_q - 4'h1;
         else if (cmd_d == SDCD_WR || cmd_d == SDCD_RD)
            burst_q <= chop_d ? SDCD_BURST_BC4 : SDCD_BURST_BL8;
      end
   end

   // power state machine
   always_ff @(posedge SYS_CLK)
   begin
      if (rst_any)
         st_q <= SDCD_ST_IDLE;
      else if (CLK_EN)
      begin
         unique case (st_q)
            SDCD_ST_IDLE:
            begin
               if (cmd_d == SDCD_SRE)
                  st_q <= SDCD_ST_SR;
               else if (cmd_d == SDCD_PDE)
                  st_q <= SDCD_ST_PD;
            end
            SDCD_ST_PD:
               if (cmd_d == SDCD_PDX)
                  st_q <= SDCD_ST_IDLE;
            SDCD_ST_SR:
               if (cmd_d == SDCD_SRX)
                  st_q <= SDCD_ST_IDLE;
            default:
               st_q <= SDCD_ST_IDLE;
         endcase
      end
   end

   // refresh pulse, suppressed while powered down
   always_ff @(posedge SYS_CLK)
   begin
      if (rst_any)
         ref_q <= 1'b0;
      else if (CLK_EN)
         ref_q <= (cmd_d == SDCD_REF) && (st_q != SDCD_ST_PD);
   end

   // odt status only, never part of the decode
   always_ff @(posedge SYS_CLK)
   begin
      if (rst_any)
         odt_q <= 1'b0;
      else if (CLK_EN)
         odt_q <= ODT && (st_q != SDCD_ST_SR);
   end

   // sixth mode register write
   always_ff @(posedge SYS_CLK)
   begin
      if (rst_any)
      begin
         mr6_q  <= SDCD_MR6_RST;
         rate_q <= SDCD_RATE_RST;
      end
      else if (CLK_EN && cmd_d == SDCD_MRS && {BG, BA[1]} == SDCD_MR6_SEL)
      begin
         mr6_q  <= ADDR[7:0];
         rate_q <= ADDR[SDCD_RATE_LSB +: 3];
      end
   end

   // reference level in hundredths of percent, value clamped
   always_ff @(posedge SYS_CLK)
   begin
      if (rst_any)
         lvl_q <= 14'h0000;
      else if (CLK_EN)
         lvl_q <= 14'((mr6_q[SDCD_MR6_RNG_BIT] ? SDCD_RANGE2_BASE
                  : SDCD_RANGE1_BASE) + SDCD_STEP *
                  int'((mr6_q[5:0] > SDCD_VAL_MAX) ? SDCD_VAL_MAX
                  : mr6_q[5:0]));
   end

   // outputs
   assign CMD          = cmd_q;
   assign CMD_VALID    = valid_q;
   assign CMD_BG       = bg_q;
   assign CMD_BA       = ba_q;
   assign ROW_ADDR     = row_q;
   assign AUTO_PRE     = ap_q;
   assign CHOP4        = chop_q;
   assign BURST_BUSY   = (burst_q != 4'h0);
   assign POWER_DOWN   = (st_q == SDCD_ST_PD);
   assign SELF_REFRESH = (st_q == SDCD_ST_SR);
   assign REFRESH_REQ  = ref_q;
   assign ODT_ACTIVE   = odt_q;
   assign DATA_RATE    = rate_q;
   assign CAL_ENABLE   = mr6_q[SDCD_MR6_EN_BIT];
   assign CAL_RANGE    = mr6_q[SDCD_MR6_RNG_BIT];
   assign CAL_VALUE    = mr6_q[5:0];
   assign REF_LEVEL_BP = lvl_q;
   // monitor drives dq0 only while calibration runs
   assign DQ_OUT       = 4'h0;
   assign DQ_OE        = {3'h0, mr6_q[SDCD_MR6_EN_BIT]};

   // assertions
   a_mr6_write_takes: assert property (@(posedge SYS_CLK) disable iff (rst_any)
      CLK_EN && !CS_N && ACT_N && !RAS_N_A16 && !CAS_N_A15 && !WE_N_A14
      && cke_q && CKE && BG == 2'h3 && !BA[1]
      |=> CAL_VALUE == $past(ADDR[5:0]))
      else $error("mr6 write not stored");
   a_deselect_decode: assert property (@(posedge SYS_CLK) disable iff (rst_any)
      CLK_EN && CS_N && cke_q && CKE |=> CMD == SDCD_DES && !CMD_VALID)
      else $error("deselect not decoded");
   a_write_decode: assert property (@(posedge SYS_CLK) disable iff (rst_any)
      CLK_EN && !CS_N && ACT_N && RAS_N_A16 && !CAS_N_A15 && !WE_N_A14
      && cke_q && CKE |=> CMD == SDCD_WR)
      else $error("write not decoded");
   a_read_decode: assert property (@(posedge SYS_CLK) disable iff (rst_any)
      CLK_EN && !CS_N && ACT_N && RAS_N_A16 && !CAS_N_A15 && WE_N_A14
      && cke_q && CKE |=> CMD == SDCD_RD && AUTO_PRE == $past(ADDR[10]))
      else $error("read not decoded");
   a_act_row_bits: assert property (@(posedge SYS_CLK) disable iff (rst_any)
      CLK_EN && !CS_N && !ACT_N && cke_q && CKE
      |=> CMD == SDCD_ACT && ROW_ADDR[16] == $past(RAS_N_A16))
      else $error("activate row bits wrong");
   a_burst_runs: assert property (@(posedge SYS_CLK) disable iff (rst_any)
      CLK_EN && burst_q != 4'h0 |=> burst_q == $past(burst_q) - 4'h1)
      else $error("burst cut short");
   a_chop_fixed: assert property (@(posedge SYS_CLK) disable iff (rst_any)
      CLK_EN && !CS_N && ACT_N && RAS_N_A16 && !CAS_N_A15 && cke_q && CKE
      && !OTF_BURST_EN |=> CHOP4 == $past(BC4_FIXED))
      else $error("fixed chop not taken");
   a_no_pd_refresh: assert property (@(posedge SYS_CLK) disable iff (rst_any)
      POWER_DOWN && CLK_EN |=> !REFRESH_REQ)
      else $error("refresh in power-down");
   a_odt_off_sr: assert property (@(posedge SYS_CLK) disable iff (rst_any)
      SELF_REFRESH && CLK_EN |=> !ODT_ACTIVE || !SELF_REFRESH)
      else $error("odt active in self refresh");
   a_monitor_pin: assert property (@(posedge SYS_CLK) disable iff (rst_any)
      DQ_OE[0] == CAL_ENABLE && DQ_OE[3:1] == 3'h0)
      else $error("reference monitor pin wrong");
endmodule
